// ==== hw/tecc_pkg.sv ====
// Shared constants and types for the time elapsed capture counter
package tecc_pkg;

    // ------------------------------------------------------------
    // Counter geometry and clock division
    // ------------------------------------------------------------
    localparam int TECC_COUNT_WIDTH = 40;
    localparam int TECC_DIV_ACOUSTIC = 8;
    localparam int TECC_DIV_LC = 20;
    localparam int TECC_PRESCALE_WIDTH = 5;
    localparam int TECC_BYTE_COUNT = 5;

    // ------------------------------------------------------------
    // Control field encodings
    // ------------------------------------------------------------
    localparam logic TECC_SRC_ACOUSTIC = 1'b0;
    localparam logic TECC_SRC_LC = 1'b1;
    localparam logic TECC_TRIG_CHIP_SELECT = 1'b0;
    localparam logic TECC_TRIG_PIN = 1'b1;
    localparam logic [7:0] TECC_PIN_FUNC_CAPTURE = 8'h27;
    localparam logic TECC_POL_ACTIVE_HIGH = 1'b0;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [TECC_COUNT_WIDTH-1:0] TECC_COUNT_RESET = 40'h00_0000_0000;
    localparam logic TECC_CS_IDLE_LEVEL = 1'b1;
    localparam logic TECC_PIN_IDLE_LEVEL = 1'b0;

    // ------------------------------------------------------------
    // Timing seen by the trigger source (kept for reference by tests)
    // ------------------------------------------------------------
    localparam int TECC_CLK_PERIOD_NS = 50;
    localparam int TECC_REARM_GAP_NS = 1000;
    localparam int TECC_REARM_GAP_CYCLES = (TECC_REARM_GAP_NS + TECC_CLK_PERIOD_NS - 1) / TECC_CLK_PERIOD_NS;
    localparam int TECC_SYNC_LATENCY_MAX = 5;

    // Arm state of the pin capture path
    typedef enum logic [1:0] {
        TECC_ARM_READY = 2'b01,
        TECC_ARM_HELD = 2'b10
    } tecc_arm_type;

endpackage : tecc_pkg

// ==== hw/tecc_pin_sync.sv ====
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module tecc_pin_sync
    import tecc_pkg::*;
#(
    parameter logic RESET_LEVEL = 1'b0
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic pin_async,
    output logic pin_level
);

    logic stage1;
    logic stage2;
    logic stage3;

    // ------------------------------------------------------------
    // Synchroniser chain
    // ------------------------------------------------------------
    // First stage feeds only the second; metastability stays contained
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            stage1 <= RESET_LEVEL;
            stage2 <= RESET_LEVEL;
            stage3 <= RESET_LEVEL;
        end else begin
            stage1 <= pin_async;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // A change counts only once stages two and three agree
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pin_level <= RESET_LEVEL;
        end else if (stage2 == stage3) begin
            pin_level <= stage3;
        end
    end

endmodule : tecc_pin_sync

// ==== hw/tecc_counter.sv ====
// Elapsed time counter with chip-select and pin triggered capture
`timescale 1ns/1ps
module tecc_counter
    import tecc_pkg::*;
#(
    parameter int COUNT_WIDTH = TECC_COUNT_WIDTH,
    parameter int DIV_ACOUSTIC = TECC_DIV_ACOUSTIC,
    parameter int DIV_LC = TECC_DIV_LC
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic osc_acoustic_tick,
    input wire logic osc_lc_tick,
    input wire logic counter_clock_source_sel,
    input wire logic capture_trigger_source,
    input wire logic counter_enable_bit,
    input wire logic counter_clear_ctrl,
    input wire logic [7:0] pin_function_select,
    input wire logic pin_polarity_setting,
    input wire logic serial_chip_select_pin,
    input wire logic trigger_pin,
    input wire logic msb_read_pulse,
    input wire logic lsb_read_pulse,
    input wire logic [2:0] count_byte_sel,
    output logic [COUNT_WIDTH-1:0] captured_count_field,
    output logic [7:0] count_byte,
    output logic validation_osc_sel,
    output logic validation_osc_changed,
    output logic capture_blocked
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    generate
        if (COUNT_WIDTH != TECC_BYTE_COUNT * 8) begin : g_bad_width
            $error("count width must fill exactly five bytes");
        end
        if (DIV_ACOUSTIC < 2 || DIV_LC < 2 || DIV_ACOUSTIC > 32 || DIV_LC > 32) begin : g_bad_div
            $error("divider ratios must lie between 2 and 32");
        end
    endgenerate

    localparam logic [TECC_PRESCALE_WIDTH-1:0] LAST_ACOUSTIC = TECC_PRESCALE_WIDTH'(DIV_ACOUSTIC - 1);
    localparam logic [TECC_PRESCALE_WIDTH-1:0] LAST_LC = TECC_PRESCALE_WIDTH'(DIV_LC - 1);
    localparam logic [COUNT_WIDTH-1:0] COUNT_MAX = {COUNT_WIDTH{1'b1}};

    logic [COUNT_WIDTH-1:0] elapsed_time_counter;
    logic [TECC_PRESCALE_WIDTH-1:0] prescale;
    logic [TECC_PRESCALE_WIDTH-1:0] prescale_last;
    logic src_tick;
    logic advance;
    logic count_run;
    logic source_prev;
    logic cs_level;
    logic cs_level_prev;
    logic pin_level;
    logic pin_level_prev;
    logic cs_fall;
    logic pin_edge;
    logic pin_is_trigger;
    logic cs_blocked;
    logic cs_capture;
    logic pin_capture;
    tecc_arm_type arm_state;
    tecc_arm_type next_arm_state;

    // ------------------------------------------------------------
    // Counter clock selection and division
    // ------------------------------------------------------------
    // Source select picks the oscillator tick and its divide ratio
    assign src_tick = (counter_clock_source_sel == TECC_SRC_LC) ? osc_lc_tick : osc_acoustic_tick;
    assign prescale_last = (counter_clock_source_sel == TECC_SRC_LC) ? LAST_LC : LAST_ACOUSTIC;
    assign count_run = counter_enable_bit && (counter_clear_ctrl == 1'b0);
    assign advance = count_run && src_tick && (prescale == prescale_last);

    // Prescaler restarts on a source change so the first period is whole
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            prescale <= '0;
        end else if (!count_run || (source_prev != counter_clock_source_sel)) begin
            prescale <= '0;
        end else if (src_tick) begin
            prescale <= (prescale == prescale_last) ? '0 : prescale + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Free-running elapsed time counter
    // ------------------------------------------------------------
    // Held at zero while disabled, so enabling starts from zero
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            elapsed_time_counter <= TECC_COUNT_RESET;
        end else if (!count_run) begin
            elapsed_time_counter <= TECC_COUNT_RESET;
        end else if (advance) begin
            elapsed_time_counter <= elapsed_time_counter + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Reference validation oscillator select
    // ------------------------------------------------------------
    // The change pulse lets validation logic requalify its references
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            source_prev <= TECC_SRC_ACOUSTIC;
            validation_osc_sel <= TECC_SRC_ACOUSTIC;
            validation_osc_changed <= 1'b0;
        end else begin
            source_prev <= counter_clock_source_sel;
            validation_osc_sel <= counter_clock_source_sel;
            validation_osc_changed <= (source_prev != counter_clock_source_sel);
        end
    end

    // ------------------------------------------------------------
    // Trigger synchronisation and edge detection
    // ------------------------------------------------------------
    tecc_pin_sync #(
        .RESET_LEVEL(TECC_CS_IDLE_LEVEL)
    ) u_cs_sync (
        .mclk(mclk),
        .rst_b(rst_b),
        .pin_async(serial_chip_select_pin),
        .pin_level(cs_level)
    );

    tecc_pin_sync #(
        .RESET_LEVEL(TECC_PIN_IDLE_LEVEL)
    ) u_pin_sync (
        .mclk(mclk),
        .rst_b(rst_b),
        .pin_async(trigger_pin),
        .pin_level(pin_level)
    );

    // Edge history on the filtered levels only
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cs_level_prev <= TECC_CS_IDLE_LEVEL;
            pin_level_prev <= TECC_PIN_IDLE_LEVEL;
        end else begin
            cs_level_prev <= cs_level;
            pin_level_prev <= pin_level;
        end
    end

    // Polarity 0 takes rising edges, 1 takes falling edges
    assign cs_fall = cs_level_prev && !cs_level;
    assign pin_edge = (pin_polarity_setting == TECC_POL_ACTIVE_HIGH) ?
        (!pin_level_prev && pin_level) : (pin_level_prev && !pin_level);
    assign pin_is_trigger = (pin_function_select == TECC_PIN_FUNC_CAPTURE);

    // ------------------------------------------------------------
    // Capture qualification
    // ------------------------------------------------------------
    assign cs_capture = counter_enable_bit && (capture_trigger_source == TECC_TRIG_CHIP_SELECT)
        && cs_fall && !cs_blocked;
    assign pin_capture = counter_enable_bit && (capture_trigger_source == TECC_TRIG_PIN)
        && pin_is_trigger && pin_edge && (arm_state == TECC_ARM_READY);

    // MSB read blocks chip-select capture; LSB read re-arms, set wins
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cs_blocked <= 1'b0;
        end else if (msb_read_pulse) begin
            cs_blocked <= 1'b1;
        end else if (lsb_read_pulse) begin
            cs_blocked <= 1'b0;
        end
    end

    // Pin arm state: an edge in the re-arm cycle is not captured; READY from the next cycle
    always_comb begin
        next_arm_state = arm_state;
        unique case (arm_state)
            TECC_ARM_READY: begin
                if (pin_capture) begin
                    next_arm_state = TECC_ARM_HELD;
                end
            end
            TECC_ARM_HELD: begin
                if (lsb_read_pulse) begin
                    next_arm_state = TECC_ARM_READY;
                end
            end
            default: begin
                next_arm_state = TECC_ARM_READY;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            arm_state <= TECC_ARM_READY;
        end else begin
            arm_state <= next_arm_state;
        end
    end

    assign capture_blocked = (capture_trigger_source == TECC_TRIG_PIN) ? (arm_state == TECC_ARM_HELD) : cs_blocked;

    // ------------------------------------------------------------
    // Capture field and byte readback
    // ------------------------------------------------------------
    // Count and capture share one clock, so the sample is always stable
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            captured_count_field <= TECC_COUNT_RESET;
        end else if (cs_capture || pin_capture) begin
            captured_count_field <= elapsed_time_counter;
        end
    end

    // Byte 0 is the LSB; selections past byte 4 read as zero
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            count_byte <= 8'h00;
        end else if (count_byte_sel < 3'(TECC_BYTE_COUNT)) begin
            count_byte <= captured_count_field[count_byte_sel*8 +: 8];
        end else begin
            count_byte <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    // Pin settled high, then low long enough to reach the filtered level
    sequence s_cs_pin_fall;
        serial_chip_select_pin [*3] ##1 !serial_chip_select_pin [*5];
    endsequence

    sequence s_cs_armed_mode;
        counter_enable_bit && (capture_trigger_source == TECC_TRIG_CHIP_SELECT) && !cs_blocked
            && !msb_read_pulse;
    endsequence

    sequence s_msb_then_lsb;
        msb_read_pulse ##[1:64] (lsb_read_pulse && !msb_read_pulse);
    endsequence

    hold_zero_a: assert property (!counter_enable_bit |=> elapsed_time_counter == '0)
        else $error("counter not held at zero while disabled");

    clear_zero_a: assert property (counter_clear_ctrl |=> elapsed_time_counter == '0)
        else $error("counter not zero while clear is set");

    wrap_zero_a: assert property (advance && elapsed_time_counter == COUNT_MAX |=> elapsed_time_counter == '0)
        else $error("counter did not wrap to zero");

    step_one_a: assert property (count_run && advance && elapsed_time_counter != COUNT_MAX
        |=> elapsed_time_counter == $past(elapsed_time_counter) + 1'b1)
        else $error("counter did not advance by one");

    no_step_a: assert property (count_run && !advance |=> $stable(elapsed_time_counter))
        else $error("counter moved without a divided clock");

    acoustic_div_a: assert property (advance && counter_clock_source_sel == TECC_SRC_ACOUSTIC
        |-> osc_acoustic_tick && prescale == LAST_ACOUSTIC)
        else $error("acoustic source not divided by eight");

    lc_div_a: assert property (advance && counter_clock_source_sel == TECC_SRC_LC
        |-> osc_lc_tick && prescale == LAST_LC)
        else $error("LC source not divided by twenty");

    start_zero_a: assert property ($rose(counter_enable_bit) && !counter_clear_ctrl
        |-> elapsed_time_counter == '0)
        else $error("counting did not start from zero");

    cs_capture_a: assert property (cs_capture |=> captured_count_field == $past(elapsed_time_counter))
        else $error("chip select fall did not capture the count");

    cs_prompt_a: assert property (s_cs_pin_fall ##0 s_cs_armed_mode |-> cs_capture)
        else $error("chip select capture later than the synchroniser delay");

    msb_block_a: assert property (cs_blocked && capture_trigger_source == TECC_TRIG_CHIP_SELECT
        |=> $stable(captured_count_field))
        else $error("capture updated after MSB read");

    rearm_read_a: assert property (s_msb_then_lsb |=> !cs_blocked)
        else $error("LSB read did not re-arm capture");

    pin_capture_a: assert property (pin_capture |=> captured_count_field == $past(elapsed_time_counter)
        && arm_state == TECC_ARM_HELD)
        else $error("pin edge did not capture and hold");

    pin_polarity_a: assert property (pin_capture && pin_polarity_setting == TECC_POL_ACTIVE_HIGH
        |-> pin_level && !pin_level_prev)
        else $error("active high pin captured on a falling edge");

    pin_held_a: assert property (arm_state == TECC_ARM_HELD && capture_trigger_source == TECC_TRIG_PIN
        && !lsb_read_pulse |=> $stable(captured_count_field) && arm_state == TECC_ARM_HELD)
        else $error("pin capture updated before LSB read");

    route_sel_a: assert property ((capture_trigger_source == TECC_TRIG_PIN |-> !cs_capture)
        and (capture_trigger_source == TECC_TRIG_CHIP_SELECT |-> !pin_capture))
        else $error("capture taken from the unselected trigger");

    enable_gate_a: assert property (!counter_enable_bit |=> $stable(captured_count_field))
        else $error("capture while counter disabled");

    byte_view_a: assert property (count_byte_sel == 3'd4 |=> count_byte == $past(captured_count_field[39:32]))
        else $error("top byte readback wrong");

    valid_sel_a: assert property ($changed(counter_clock_source_sel)
        |=> validation_osc_changed && validation_osc_sel == $past(counter_clock_source_sel))
        else $error("validation oscillator select not followed");

    sync_gate_a: assert property (cs_capture |-> $past(cs_level) && !cs_level)
        else $error("capture not from synchronised chip select");

endmodule : tecc_counter

// ==== sim/tecc_host_model.sv ====
// Host processor and trigger source model for the elapsed time counter
`timescale 1ns/1ps
module tecc_host_model
    import tecc_pkg::*;
(
    input wire logic mclk,
    output logic serial_chip_select_pin,
    output logic trigger_pin,
    output logic msb_read_pulse,
    output logic lsb_read_pulse
);
    // ------------------------------------------------------------
    // Serial frames and trigger pin
    // ------------------------------------------------------------
    int gap_left;

    // Idle levels from time zero
    initial begin
        serial_chip_select_pin = TECC_CS_IDLE_LEVEL;
        trigger_pin = TECC_PIN_IDLE_LEVEL;
        msb_read_pulse = 1'b0;
        lsb_read_pulse = 1'b0;
        gap_left = 0;
    end

    // One frame, optionally reading the capture MSB and LSB inside it
    task automatic cs_frame(input logic rd_msb, input logic rd_lsb);
        @(negedge mclk) serial_chip_select_pin = 1'b0;
        repeat (7) @(negedge mclk);
        msb_read_pulse = rd_msb;
        @(negedge mclk) msb_read_pulse = 1'b0;
        lsb_read_pulse = rd_lsb;
        @(negedge mclk) lsb_read_pulse = 1'b0;
        @(negedge mclk) serial_chip_select_pin = 1'b1;
        // Counted from the rise, so the real gap is a little longer
        if (rd_lsb) gap_left = TECC_REARM_GAP_CYCLES;
        repeat (2) @(negedge mclk);
    endtask : cs_frame

    // Move the pin, then hold the level well past the minimum
    task automatic pin_set(input logic level);
        while (gap_left > 0) begin
            @(negedge mclk);
            gap_left--;
        end
        @(negedge mclk) trigger_pin = level;
        repeat (8) @(negedge mclk);
    endtask : pin_set
endmodule : tecc_host_model

// ==== sim/tb_top.sv ====
// Self-checking testbench for the elapsed time counter
`timescale 1ns/1ps
module tb_top
    import tecc_pkg::*;
;
    // ------------------------------------------------------------
    // Signals, clock and instances
    // ------------------------------------------------------------
    logic mclk;
    logic rst_b;
    logic osc_acoustic_tick;
    logic osc_lc_tick;
    logic counter_clock_source_sel;
    logic capture_trigger_source;
    logic counter_enable_bit;
    logic counter_clear_ctrl;
    logic [7:0] pin_function_select;
    logic pin_polarity_setting;
    logic [2:0] count_byte_sel;
    logic serial_chip_select_pin;
    logic trigger_pin;
    logic msb_read_pulse;
    logic lsb_read_pulse;
    logic [TECC_COUNT_WIDTH-1:0] captured_count_field;
    logic [7:0] count_byte;
    logic validation_osc_sel;
    logic validation_osc_changed;
    logic capture_blocked;
    int fails;
    int n_checks;
    int pulses;

    // 20 MHz system clock
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    tecc_host_model host (
        .mclk(mclk),
        .serial_chip_select_pin(serial_chip_select_pin),
        .trigger_pin(trigger_pin),
        .msb_read_pulse(msb_read_pulse),
        .lsb_read_pulse(lsb_read_pulse)
    );

    tecc_counter dut (
        .mclk(mclk),
        .rst_b(rst_b),
        .osc_acoustic_tick(osc_acoustic_tick),
        .osc_lc_tick(osc_lc_tick),
        .counter_clock_source_sel(counter_clock_source_sel),
        .capture_trigger_source(capture_trigger_source),
        .counter_enable_bit(counter_enable_bit),
        .counter_clear_ctrl(counter_clear_ctrl),
        .pin_function_select(pin_function_select),
        .pin_polarity_setting(pin_polarity_setting),
        .serial_chip_select_pin(serial_chip_select_pin),
        .trigger_pin(trigger_pin),
        .msb_read_pulse(msb_read_pulse),
        .lsb_read_pulse(lsb_read_pulse),
        .count_byte_sel(count_byte_sel),
        .captured_count_field(captured_count_field),
        .count_byte(count_byte),
        .validation_osc_sel(validation_osc_sel),
        .validation_osc_changed(validation_osc_changed),
        .capture_blocked(capture_blocked)
    );

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : stop_test

    // Exactly n ticks of one oscillator, then both stop so the count freezes
    task automatic ticks(input int n, input logic lc);
        @(negedge mclk);
        osc_acoustic_tick = !lc;
        osc_lc_tick = lc;
        repeat (n) @(negedge mclk);
        osc_acoustic_tick = 1'b0;
        osc_lc_tick = 1'b0;
    endtask : ticks

    // Configuration levels move together, always from the arguments
    task automatic set_cfg(input logic src, input logic trig, input logic [7:0] func, input logic pol,
        input logic clr);
        counter_clock_source_sel = src;
        capture_trigger_source = trig;
        pin_function_select = func;
        pin_polarity_setting = pol;
        counter_clear_ctrl = clr;
    endtask : set_cfg

    // Settle time after enable also keeps pin edges clear of it
    task automatic set_en(input logic en);
        @(negedge mclk) counter_enable_bit = en;
        repeat (4) @(negedge mclk);
    endtask : set_en

    // Hard stop for a hung run
    initial begin
        #1000000;
        fails++;
        stop_test();
    end

    // ------------------------------------------------------------
    // Main sequence; ticks are frozen at every capture
    // ------------------------------------------------------------
    initial begin
        fails = 0;
        n_checks = 0;
        rst_b = 1'b0;
        osc_acoustic_tick = 1'b0;
        osc_lc_tick = 1'b0;
        set_cfg(TECC_SRC_ACOUSTIC, TECC_TRIG_CHIP_SELECT, 8'h00, TECC_POL_ACTIVE_HIGH, 1'b0);
        counter_enable_bit = 1'b0;
        count_byte_sel = 3'h0;
        repeat (8) @(negedge mclk);
        rst_b = 1'b1;
        repeat (2) @(negedge mclk);
        check(captured_count_field, 40'h0);
        // Disabled: no count, no capture
        ticks(40, 1'b0);
        host.cs_frame(1'b0, 1'b0);
        check(captured_count_field, 40'h0);
        set_en(1'b1);
        ticks(2400, 1'b0);
        host.cs_frame(1'b0, 1'b0);
        check(captured_count_field, 40'h12C);
        for (int i = 0; i < 6; i++) begin
            @(negedge mclk) count_byte_sel = 3'(i);
            @(negedge mclk);
            check(40'(count_byte), (i < TECC_BYTE_COUNT) ? ((40'h12C >> (8 * i)) & 40'hFF) : 40'h0);
        end
        // Unselected oscillator is ignored
        ticks(40, 1'b1);
        host.cs_frame(1'b0, 1'b0);
        check(captured_count_field, 40'h12C);
        // MSB read blocks chip-select capture until the LSB read
        host.cs_frame(1'b1, 1'b0);
        check(40'(capture_blocked), 40'h1);
        ticks(80, 1'b0);
        host.cs_frame(1'b0, 1'b0);
        check(captured_count_field, 40'h12C);
        host.cs_frame(1'b0, 1'b1);
        check(40'(capture_blocked), 40'h0);
        host.cs_frame(1'b0, 1'b0);
        check(captured_count_field, 40'h136);
        ticks(8, 1'b0);
        host.cs_frame(1'b1, 1'b1);
        check(captured_count_field, 40'h137);
        ticks(8, 1'b0);
        host.cs_frame(1'b0, 1'b0);
        check(captured_count_field, 40'h138);
        // Clear control holds the count at zero
        @(negedge mclk) set_cfg(TECC_SRC_ACOUSTIC, TECC_TRIG_CHIP_SELECT, 8'h00, TECC_POL_ACTIVE_HIGH, 1'b1);
        ticks(80, 1'b0);
        host.cs_frame(1'b0, 1'b0);
        check(captured_count_field, 40'h0);
        @(negedge mclk) set_cfg(TECC_SRC_ACOUSTIC, TECC_TRIG_CHIP_SELECT, 8'h00, TECC_POL_ACTIVE_HIGH, 1'b0);
        // LC source: one validation change pulse, divide by twenty
        @(negedge mclk) set_cfg(TECC_SRC_LC, TECC_TRIG_CHIP_SELECT, 8'h00, TECC_POL_ACTIVE_HIGH, 1'b0);
        pulses = 0;
        repeat (3) begin
            @(negedge mclk);
            if (validation_osc_changed === 1'b1) pulses++;
        end
        check(40'(pulses), 40'h1);
        check(40'(validation_osc_sel), 40'h1);
        set_en(1'b0);
        set_en(1'b1);
        ticks(40, 1'b0);
        ticks(60, 1'b1);
        host.cs_frame(1'b0, 1'b0);
        check(captured_count_field, 40'h3);
        // Pin trigger, rising edge, then held until the LSB read
        @(negedge mclk) set_cfg(TECC_SRC_ACOUSTIC, TECC_TRIG_PIN, TECC_PIN_FUNC_CAPTURE, TECC_POL_ACTIVE_HIGH, 1'b0);
        set_en(1'b0);
        set_en(1'b1);
        ticks(16, 1'b0);
        host.pin_set(1'b1);
        host.pin_set(1'b0);
        check(captured_count_field, 40'h2);
        check(40'(capture_blocked), 40'h1);
        ticks(16, 1'b0);
        host.pin_set(1'b1);
        host.pin_set(1'b0);
        check(captured_count_field, 40'h2);
        host.cs_frame(1'b0, 1'b0);
        check(captured_count_field, 40'h2);
        host.cs_frame(1'b0, 1'b1);
        host.pin_set(1'b1);
        host.pin_set(1'b0);
        check(captured_count_field, 40'h4);
        host.cs_frame(1'b0, 1'b1);
        // Inverted polarity: only the falling edge captures
        @(negedge mclk) set_cfg(TECC_SRC_ACOUSTIC, TECC_TRIG_PIN, TECC_PIN_FUNC_CAPTURE, 1'b1, 1'b0);
        ticks(8, 1'b0);
        host.pin_set(1'b1);
        check(captured_count_field, 40'h4);
        host.pin_set(1'b0);
        check(captured_count_field, 40'h5);
        host.cs_frame(1'b0, 1'b1);
        // Any other pin function leaves the pin out of capture
        @(negedge mclk) set_cfg(TECC_SRC_ACOUSTIC, TECC_TRIG_PIN, 8'h26, TECC_POL_ACTIVE_HIGH, 1'b0);
        ticks(8, 1'b0);
        host.pin_set(1'b1);
        host.pin_set(1'b0);
        check(captured_count_field, 40'h5);
        stop_test();
    end
endmodule : tb_top
